// >>> hdl/sc_a_ctrl_regs.v
// How it works
// R1: Bits 7..5 of control 1 pick the A and C branch sources.
// R2: Select MSB high overrides low bits; A and C share one common source.
// R3: Codes 000..011 pick one of four A sources; C stays on first source.
// R4: Code 100 is the fifth A source; 101..111 are reserved.
// R5: Bits 4..0 of control 1 are the B capacitor size, 0..31 units.
// R6: Control 1 is fully read/write and clears to zero at reset.
// R7: Four control 1 copies at indices 81h, 89h, 95h, 9Dh, both banks.
// R8: Control 2 is fully read/write and clears to zero at reset.
// R9: Control 2 bit 7 enables analog bus drive; otherwise tri-stated.
// R10: With phase select 0, drive analog bus only late in phase two.
// R11: With phase select 1, drive analog bus continuously.
// R12: Control 2 bit 6 gates comparator result onto comparator bus.
// R13: An undriven comparator bus is pulled low.
// R14: Comparator sampled at internal phase one rise, held through phase two.
// R15: Control 2 bit 5 enables auto-zero shorting and branch switches.
// R16: Control 2 bits 4..0 hold the C capacitor size code.
// R17: Four control 2 copies at indices 82h, 8Ah, 96h, 9Eh, both banks.
// R18: Phase select swaps internal first and second clock phases.
// R19: Feedback switch: off, always on, or phase two only under auto-zero.
// R20: C capacitor code is plain binary, 0..31 units.
// R21: Registers update only on addressed writes; reads have no side effects.
`timescale 1ns/1ps
`default_nettype none
`include "sc_a_ctrl_map.vh"

module sc_a_ctrl_regs (
  // Clock and reset
  input wire I_MCLK,
  input wire I_RSTN,
  // APB slave
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [`APB_AW-1:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output wire [31:0] O_PRDATA,
  output reg O_PREADY,
  output reg O_PSLVERR,
  // Clock phases and late part of phase two
  input wire I_FIRST_CLOCK_PHASE,
  input wire I_SECOND_CLOCK_PHASE,
  input wire I_SAMPLE_LATE,
  // Per block inputs from neighbouring registers and comparators
  input wire [`NUM_BLK-1:0] I_PHASE_SWAP,
  input wire [`NUM_BLK-1:0] I_INTEGRATOR_FEEDBACK_SWITCH,
  input wire [`NUM_BLK-1:0] I_COMP,
  // Per block controls to the analog array
  output wire [`NUM_BLK*`SEL_W-1:0] O_A_SRC_SEL,
  output wire [`NUM_BLK-1:0] O_C_SRC_SEL,
  output wire [`NUM_BLK-1:0] O_SEL_RESERVED,
  output wire [`NUM_BLK*`CAP_W-1:0] O_B_BRANCH_CAP_SIZE,
  output wire [`NUM_BLK*`CAP_W-1:0] O_C_BRANCH_CAP_SIZE,
  output wire [`NUM_BLK-1:0] O_ABUS_OE,
  output wire [`NUM_BLK-1:0] O_COLUMN_COMPARATOR_BUS,
  output wire [`NUM_BLK-1:0] O_AZ_SHORT,
  output wire [`NUM_BLK-1:0] O_FB_SW
);

  // Address decode: {hit, slot}. Both banks alias the same storage.
  function [`SLOT_W:0] decode;
    input [`APB_AW-1:0] addr;
    reg [7:0] idx;
    begin
      idx = addr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
      decode = {1'b0, 3'h0};
      if (!addr[`ADDR_TOP_BIT]) begin
        case (idx)
          `IDX_BLK10_CR1: decode = {1'b1, 3'h0};
          `IDX_BLK12_CR1: decode = {1'b1, 3'h1};
          `IDX_BLK21_CR1: decode = {1'b1, 3'h2};
          `IDX_BLK23_CR1: decode = {1'b1, 3'h3};
          `IDX_BLK10_CR2: decode = {1'b1, 3'h4};
          `IDX_BLK12_CR2: decode = {1'b1, 3'h5};
          `IDX_BLK21_CR2: decode = {1'b1, 3'h6};
          `IDX_BLK23_CR2: decode = {1'b1, 3'h7};
          default: decode = {1'b0, 3'h0};
        endcase
      end
    end
  endfunction

  // Override forces the common source whatever the two low bits hold
  function [`SEL_W-1:0] a_source;
    input [`SEL_W-1:0] code;
    begin
      if (code[`SEL_W-1]) begin
        a_source = `SEL_COMMON;
      end else begin
        a_source = code;
      end
    end
  endfunction

  // Codes past the common one are flagged reserved; both branches still take the common source
  function sel_reserved;
    input [`SEL_W-1:0] code;
    begin
      sel_reserved = code[`SEL_W-1] & (code != `SEL_COMMON);
    end
  endfunction

  // Picks the external phase that acts as a given internal phase
  function phase_pick;
    input swap;
    input own;
    input other;
    begin
      if (swap) begin
        phase_pick = other;
      end else begin
        phase_pick = own;
      end
    end
  endfunction

  // APB phases
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SETUP = 3'b010;
  localparam [2:0] ST_ACCESS = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;

  wire [`SLOT_W:0] dec;
  wire hit;
  wire [`SLOT_W-1:0] slot;
  wire setup;
  wire access;
  wire wr_en;
  wire rd_en;
  wire [`REG_W-1:0] rdata;
  wire [`NUM_SLOT*`REG_W-1:0] flat;

  assign dec = decode(I_PADDR);
  assign hit = dec[`SLOT_W];
  assign slot = dec[`SLOT_W-1:0];
  assign setup = I_PSEL & ~I_PENABLE;
  assign access = I_PSEL & I_PENABLE;

  // Writes land only at the completing access edge
  assign wr_en = access & O_PREADY & I_PWRITE & hit; // R21 R6 R8
  // Reads are launched in setup so data is ready for the access phase
  assign rd_en = setup & ~I_PWRITE & hit; // R7 R17

  always @* begin
    next_state = ST_IDLE;
    case (state)
      ST_IDLE: begin
        next_state = setup ? ST_SETUP : ST_IDLE;
      end
      ST_SETUP: begin
        next_state = ST_ACCESS;
      end
      ST_ACCESS: begin
        next_state = setup ? ST_SETUP : ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Zero wait states: ready rises for exactly the cycle after setup
  always @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      O_PREADY <= 1'b0;
    end else begin
      O_PREADY <= (next_state == ST_SETUP);
    end
  end

  // An unmapped address still completes, but flags an error
  always @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      O_PSLVERR <= 1'b0;
    end else begin
      O_PSLVERR <= setup & ~hit;
    end
  end

  sc_a_reg_file u_regs (
    .i_clk(I_MCLK),
    .i_rst_n(I_RSTN),
    .i_we(wr_en),
    .i_waddr(slot),
    .i_wdata(I_PWDATA[`REG_W-1:0]),
    .i_re(rd_en),
    .i_raddr(slot),
    .o_rdata(rdata),
    .o_flat(flat)
  );

  // Upper bits read as zero
  assign O_PRDATA = {24'h000000, rdata};

  genvar b;
  generate
    for (b = 0; b < `NUM_BLK; b = b + 1) begin : g_blk
      wire [`REG_W-1:0] cr1;
      wire [`REG_W-1:0] cr2;
      wire [`SEL_W-1:0] sel_code;
      wire int_first_clock_phase;
      wire int_second_clock_phase;
      reg int_first_clock_phase_d;
      reg comp_hold;
      reg [`SEL_W-1:0] a_sel;
      reg c_sel;
      reg sel_rsvd;
      reg [`CAP_W-1:0] b_branch_cap_size;
      reg [`CAP_W-1:0] c_branch_cap_size;
      reg abus_oe;
      reg column_comparator_bus;
      reg az_short;
      reg fb_sw;
      wire [`CAP_W-1:0] b_branch_cap_size_field;
      wire [`CAP_W-1:0] c_branch_cap_size_field;
      wire abus_en;
      wire column_comparator_bus_en;
      wire az_en;
      wire first_clock_phase_rise;

      assign cr1 = flat[b*`REG_W +: `REG_W];
      assign cr2 = flat[(b+`NUM_BLK)*`REG_W +: `REG_W];
      assign sel_code = cr1[`SEL_MSB:`SEL_LSB]; // R1
      assign b_branch_cap_size_field = cr1[`B_BRANCH_CAP_SIZE_MSB:`B_BRANCH_CAP_SIZE_LSB]; // R5
      assign c_branch_cap_size_field = cr2[`C_BRANCH_CAP_SIZE_MSB:`C_BRANCH_CAP_SIZE_LSB]; // R16 R20
      assign abus_en = cr2[`ABUS_EN_BIT]; // R9
      assign column_comparator_bus_en = cr2[`COLUMN_COMPARATOR_BUS_EN_BIT]; // R12
      assign az_en = cr2[`AZ_EN_BIT]; // R15

      // Phase select swaps which external phase acts as phase one
      assign int_first_clock_phase = phase_pick(I_PHASE_SWAP[b], I_FIRST_CLOCK_PHASE, I_SECOND_CLOCK_PHASE); // R18
      assign int_second_clock_phase = phase_pick(I_PHASE_SWAP[b], I_SECOND_CLOCK_PHASE, I_FIRST_CLOCK_PHASE); // R18
      assign first_clock_phase_rise = int_first_clock_phase & ~int_first_clock_phase_d;

      // Comparator is captured once per phase one rise and held, so
      // the bus stays stable all through phase two
      always @(posedge I_MCLK) begin
        if (!I_RSTN) begin
          int_first_clock_phase_d <= 1'b0;
          comp_hold <= 1'b0;
        end else begin
          int_first_clock_phase_d <= int_first_clock_phase;
          if (first_clock_phase_rise) begin
            comp_hold <= I_COMP[b]; // R14
          end
        end
      end

      // Source selection; the override forces the common source
      always @(posedge I_MCLK) begin
        if (!I_RSTN) begin
          a_sel <= 3'h0;
          c_sel <= 1'b0;
          sel_rsvd <= 1'b0;
        end else begin
          a_sel <= a_source(sel_code); // R2 R3 R4
          c_sel <= cr1[`SEL_OVERRIDE]; // R2 R3
          sel_rsvd <= sel_reserved(sel_code); // R4
        end
      end

      always @(posedge I_MCLK) begin
        if (!I_RSTN) begin
          b_branch_cap_size <= 5'h00;
        end else begin
          b_branch_cap_size <= b_branch_cap_size_field; // R5
        end
      end

      always @(posedge I_MCLK) begin
        if (!I_RSTN) begin
          c_branch_cap_size <= 5'h00;
        end else begin
          c_branch_cap_size <= c_branch_cap_size_field; // R16 R20
        end
      end

      // Without phase select the bus acts as a sample-and-hold, so
      // intermediate switch states never disturb it
      always @(posedge I_MCLK) begin
        if (!I_RSTN) begin
          abus_oe <= 1'b0;
        end else if (!abus_en) begin
          abus_oe <= 1'b0; // R9
        end else if (I_PHASE_SWAP[b]) begin
          abus_oe <= 1'b1; // R11
        end else begin
          abus_oe <= int_second_clock_phase & I_SAMPLE_LATE; // R10
        end
      end

      // Bus level is low whenever this block does not drive it
      always @(posedge I_MCLK) begin
        if (!I_RSTN) begin
          column_comparator_bus <= 1'b0;
        end else begin
          column_comparator_bus <= column_comparator_bus_en & comp_hold; // R12 R13
        end
      end

      always @(posedge I_MCLK) begin
        if (!I_RSTN) begin
          az_short <= 1'b0;
        end else begin
          az_short <= az_en; // R15
        end
      end

      // Under auto-zero the feedback switch may close only in phase two
      always @(posedge I_MCLK) begin
        if (!I_RSTN) begin
          fb_sw <= 1'b0;
        end else if (!I_INTEGRATOR_FEEDBACK_SWITCH[b]) begin
          fb_sw <= 1'b0; // R19
        end else if (az_en) begin
          fb_sw <= int_second_clock_phase; // R19
        end else begin
          fb_sw <= 1'b1; // R19
        end
      end

      assign O_A_SRC_SEL[b*`SEL_W +: `SEL_W] = a_sel;
      assign O_C_SRC_SEL[b] = c_sel;
      assign O_SEL_RESERVED[b] = sel_rsvd;
      assign O_B_BRANCH_CAP_SIZE[b*`CAP_W +: `CAP_W] = b_branch_cap_size;
      assign O_C_BRANCH_CAP_SIZE[b*`CAP_W +: `CAP_W] = c_branch_cap_size;
      assign O_ABUS_OE[b] = abus_oe;
      assign O_COLUMN_COMPARATOR_BUS[b] = column_comparator_bus;
      assign O_AZ_SHORT[b] = az_short;
      assign O_FB_SW[b] = fb_sw;
    end
  endgenerate

endmodule // sc_a_ctrl_regs

`default_nettype wire

// >>> hdl/sc_a_ctrl_map.vh
`ifndef SC_A_CTRL_MAP_VH
`define SC_A_CTRL_MAP_VH

// Register indices; the byte address on the bus is four times the index
`define IDX_BLK10_CR1 8'h81
`define IDX_BLK12_CR1 8'h89
`define IDX_BLK21_CR1 8'h95
`define IDX_BLK23_CR1 8'h9d
`define IDX_BLK10_CR2 8'h82
`define IDX_BLK12_CR2 8'h8a
`define IDX_BLK21_CR2 8'h96
`define IDX_BLK23_CR2 8'h9e

// Bus address layout
`define APB_AW 12
`define ADDR_IDX_MSB 9
`define ADDR_IDX_LSB 2
`define ADDR_BANK_BIT 10
`define ADDR_TOP_BIT 11

// Storage geometry
`define NUM_BLK 4
`define NUM_SLOT 8
`define SLOT_W 3
`define REG_W 8
`define REG_RESET 8'h00
`define CR2_SLOT_BASE 3'h4

// First control register fields
`define SEL_MSB 7
`define SEL_LSB 5
`define SEL_OVERRIDE 7
`define SEL_COMMON 3'h4
`define B_BRANCH_CAP_SIZE_MSB 4
`define B_BRANCH_CAP_SIZE_LSB 0

// Second control register fields
`define ABUS_EN_BIT 7
`define COLUMN_COMPARATOR_BUS_EN_BIT 6
`define AZ_EN_BIT 5
`define C_BRANCH_CAP_SIZE_MSB 4
`define C_BRANCH_CAP_SIZE_LSB 0

`define CAP_W 5
`define SEL_W 3

`endif

// >>> hdl/sc_a_reg_file.v
`timescale 1ns/1ps
`default_nettype none
`include "sc_a_ctrl_map.vh"

module sc_a_reg_file (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Write port
  input wire i_we,
  input wire [`SLOT_W-1:0] i_waddr,
  input wire [`REG_W-1:0] i_wdata,
  // Read port
  input wire i_re,
  input wire [`SLOT_W-1:0] i_raddr,
  output reg [`REG_W-1:0] o_rdata,
  // All slots, for the analog control logic
  output wire [`NUM_SLOT*`REG_W-1:0] o_flat
);

  reg [`REG_W-1:0] mem [0:`NUM_SLOT-1];
  integer k;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (k = 0; k < `NUM_SLOT; k = k + 1) begin
        mem[k] <= `REG_RESET;
      end
    end else if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Read data is registered; a miss or idle cycle reads zero
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= `REG_RESET;
    end else if (i_re) begin
      o_rdata <= mem[i_raddr];
    end else begin
      o_rdata <= `REG_RESET;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `NUM_SLOT; g = g + 1) begin : g_flat
      assign o_flat[g*`REG_W +: `REG_W] = mem[g];
    end
  endgenerate

endmodule // sc_a_reg_file

`default_nettype wire

// >>> verif/sc_a_phase_model.sv
`timescale 1ns/1ps
`default_nettype none
module sc_a_phase_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Two phases and late part of phase two
  output logic o_first_clock_phase,
  output logic o_second_clock_phase,
  output logic o_late
);
  logic [2:0] cnt;
  // Dead cycle between phases keeps them non-overlapping
  always @(posedge i_clk) begin
    if (!i_rst_n) cnt <= 3'h0;
    else cnt <= cnt + 3'h1;
  end
  assign o_first_clock_phase = (cnt >= 3'h1) && (cnt <= 3'h3);
  assign o_second_clock_phase = cnt >= 3'h5;
  assign o_late = cnt >= 3'h6;
endmodule // sc_a_phase_model
`default_nettype wire

// >>> verif/sc_a_ctrl_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sc_a_ctrl_regs_asserts (
  input wire I_MCLK,
  input wire I_RSTN,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire [11:0] I_PADDR,
  input wire [31:0] O_PRDATA,
  input wire O_PREADY,
  input wire O_PSLVERR,
  input wire I_SAMPLE_LATE,
  input wire [3:0] I_PHASE_SWAP,
  input wire [3:0] I_INTEGRATOR_FEEDBACK_SWITCH,
  input wire [3:0] O_FB_SW,
  input wire [3:0] O_ABUS_OE,
  input wire [3:0] O_COLUMN_COMPARATOR_BUS,
  input wire [19:0] O_B_BRANCH_CAP_SIZE
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);
  sequence setup_s;
    I_PSEL && !I_PENABLE;
  endsequence
  sequence done_s;
    I_PSEL && I_PENABLE && O_PREADY;
  endsequence
  chk_ready_next: assert property (setup_s |=> done_s)
    else $error("no ready after setup");
  chk_ready_cause: assert property (O_PREADY |-> $past(I_PSEL && !I_PENABLE))
    else $error("ready without setup");
  chk_rdata_idle: assert property (!(I_PSEL && I_PENABLE) |-> O_PRDATA == 0)
    else $error("read data outside access");
  chk_rdata_upper: assert property (O_PRDATA[31:8] == 24'h000000)
    else $error("upper read data set");
  chk_err_top: assert property (setup_s ##0 I_PADDR[11] |=> O_PSLVERR)
    else $error("bad address not flagged");
  chk_err_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  chk_abus_late: assert property
    ((O_ABUS_OE & ~$past(I_PHASE_SWAP)) != 4'h0 |-> $past(I_SAMPLE_LATE))
    else $error("column drive outside late phase");
  chk_fb_off: assert property ((O_FB_SW & ~$past(I_INTEGRATOR_FEEDBACK_SWITCH)) == 4'h0)
    else $error("feedback switch on while disabled");
  chk_reset_out: assert property ($rose(I_RSTN) |-> O_ABUS_OE == 4'h0 &&
    O_COLUMN_COMPARATOR_BUS == 4'h0 && O_B_BRANCH_CAP_SIZE == 20'h0 && !O_PREADY)
    else $error("outputs not cleared by reset");
endmodule // sc_a_ctrl_regs_asserts
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module testbench;
  logic I_MCLK = 1'b0;
  logic I_RSTN = 1'b0;
  logic I_PSEL = 1'b0;
  logic I_PENABLE = 1'b0;
  logic I_PWRITE = 1'b0;
  logic [11:0] I_PADDR = 12'h000;
  logic [31:0] I_PWDATA = 32'h00000000;
  logic [3:0] I_PHASE_SWAP = 4'hf;
  logic [3:0] I_INTEGRATOR_FEEDBACK_SWITCH = 4'hf;
  logic [3:0] I_COMP = 4'hf;
  wire I_FIRST_CLOCK_PHASE, I_SECOND_CLOCK_PHASE, I_SAMPLE_LATE, O_PREADY, O_PSLVERR;
  wire [31:0] O_PRDATA;
  wire [11:0] O_A_SRC_SEL;
  wire [19:0] O_B_BRANCH_CAP_SIZE, O_C_BRANCH_CAP_SIZE;
  wire [3:0] O_C_SRC_SEL, O_SEL_RESERVED, O_ABUS_OE, O_COLUMN_COMPARATOR_BUS, O_AZ_SHORT;
  wire [3:0] O_FB_SW;
  int err_total = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] sh [2][4];
  logic [7:0] idx [2][4] = '{'{8'h81, 8'h89, 8'h95, 8'h9d},
                             '{8'h82, 8'h8a, 8'h96, 8'h9e}};
  initial begin
    forever #50 I_MCLK = ~I_MCLK;
  end
  sc_a_phase_model u_phase (.i_clk(I_MCLK), .i_rst_n(I_RSTN),
    .o_first_clock_phase(I_FIRST_CLOCK_PHASE), .o_second_clock_phase(I_SECOND_CLOCK_PHASE), .o_late(I_SAMPLE_LATE));
  sc_a_ctrl_regs u_dut (.I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .I_FIRST_CLOCK_PHASE(I_FIRST_CLOCK_PHASE), .I_SECOND_CLOCK_PHASE(I_SECOND_CLOCK_PHASE),
    .I_SAMPLE_LATE(I_SAMPLE_LATE), .I_PHASE_SWAP(I_PHASE_SWAP),
    .I_INTEGRATOR_FEEDBACK_SWITCH(I_INTEGRATOR_FEEDBACK_SWITCH), .I_COMP(I_COMP), .O_A_SRC_SEL(O_A_SRC_SEL),
    .O_C_SRC_SEL(O_C_SRC_SEL), .O_SEL_RESERVED(O_SEL_RESERVED),
    .O_B_BRANCH_CAP_SIZE(O_B_BRANCH_CAP_SIZE), .O_C_BRANCH_CAP_SIZE(O_C_BRANCH_CAP_SIZE), .O_ABUS_OE(O_ABUS_OE),
    .O_COLUMN_COMPARATOR_BUS(O_COLUMN_COMPARATOR_BUS), .O_AZ_SHORT(O_AZ_SHORT), .O_FB_SW(O_FB_SW));
  function automatic logic [2:0] asel(input logic [2:0] c);
    return c[2] ? 3'h4 : {1'b0, c[1:0]};
  endfunction
  // Bank bit is random, since both banks must alias
  function automatic logic [11:0] adr(input int k, input int b);
    return {1'b0, 1'($urandom), idx[k][b], 2'b00};
  endfunction
  // Leaves the bus selected so a following call runs back to back
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    I_PSEL <= 1'b1;
    I_PENABLE <= 1'b0;
    I_PWRITE <= w;
    I_PADDR <= a;
    I_PWDATA <= {24'h000000, d};
    @(posedge I_MCLK);
    I_PENABLE <= 1'b1;
    do begin
      @(posedge I_MCLK);
      n++;
    end while (O_PREADY !== 1'b1);
    rd = O_PRDATA;
    er = O_PSLVERR;
    `CHK(n, 1)
  endtask
  task automatic idle(input int c);
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
    repeat (c) @(posedge I_MCLK);
  endtask
  task automatic chk_outs();
    logic [7:0] v;
    logic [7:0] w;
    for (int b = 0; b < 4; b++) begin
      v = sh[0][b];
      w = sh[1][b];
      `CHK(O_A_SRC_SEL[3*b+:3], asel(v[7:5]))
      `CHK(O_C_SRC_SEL[b], v[7])
      `CHK(O_SEL_RESERVED[b], v[7:5] > 3'h4)
      `CHK(O_B_BRANCH_CAP_SIZE[5*b+:5], v[4:0])
      `CHK(O_C_BRANCH_CAP_SIZE[5*b+:5], w[4:0])
      `CHK(O_AZ_SHORT[b], w[5])
      `CHK(O_COLUMN_COMPARATOR_BUS[b], w[6])
      if (I_PHASE_SWAP[b]) `CHK(O_ABUS_OE[b], w[7])
      if (!w[7]) `CHK(O_ABUS_OE[b], 1'b0)
      if (!w[5]) `CHK(O_FB_SW[b], 1'b1)
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    end_of_test();
  end
  initial begin
    void'($urandom(8));
    repeat (12) @(posedge I_MCLK);
    I_RSTN <= 1'b1;
    @(posedge I_MCLK);
    for (int k = 0; k < 2; k++)
      for (int b = 0; b < 4; b++) begin
        apb(1'b0, adr(k, b), 8'h00);
        `CHK(rd, 32'h00000000)
        sh[k][b] = 8'h00;
      end
    $display("test reset values ended");
    for (int c = 0; c < 8; c++) begin
      sh[0][0] = {c[2:0], 5'($urandom)};
      apb(1'b1, adr(0, 0), sh[0][0]);
      idle(4);
      chk_outs();
    end
    $display("test select codes ended");
    repeat (6) begin
      I_PHASE_SWAP <= 4'($urandom);
      for (int k = 0; k < 2; k++)
        for (int b = 0; b < 4; b++) begin
          sh[k][b] = 8'($urandom);
          apb(1'b1, adr(k, b), sh[k][b]);
        end
      for (int k = 0; k < 2; k++)
        for (int b = 0; b < 4; b++) begin
          apb(1'b0, adr(k, b), 8'h00);
          `CHK(rd, {24'h000000, sh[k][b]})
        end
      idle(40);
      chk_outs();
    end
    $display("test random fields ended");
    I_INTEGRATOR_FEEDBACK_SWITCH <= 4'h0;
    I_COMP <= 4'($urandom);
    idle(40);
    `CHK(O_FB_SW, 4'h0)
    for (int b = 0; b < 4; b++)
      `CHK(O_COLUMN_COMPARATOR_BUS[b], I_COMP[b] & sh[1][b][6])
    apb(1'b1, {2'b00, 8'h80, 2'b00}, 8'hff);
    `CHK(er, 1'b1)
    apb(1'b1, {2'b10, idx[0][0], 2'b00}, 8'hff);
    `CHK(er, 1'b1)
    apb(1'b0, adr(0, 0), 8'h00);
    `CHK(rd, {24'h000000, sh[0][0]})
    idle(2);
    I_RSTN <= 1'b0;
    idle(3);
    I_RSTN <= 1'b1;
    @(posedge I_MCLK);
    apb(1'b0, adr(1, 3), 8'h00);
    `CHK(rd, 32'h00000000)
    idle(2);
    $display("test refusals and reset ended");
    end_of_test();
  end
endmodule // testbench
bind sc_a_ctrl_regs sc_a_ctrl_regs_asserts u_chk (.I_MCLK(I_MCLK),
  .I_RSTN(I_RSTN), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .I_SAMPLE_LATE(I_SAMPLE_LATE),
  .I_PHASE_SWAP(I_PHASE_SWAP), .I_INTEGRATOR_FEEDBACK_SWITCH(I_INTEGRATOR_FEEDBACK_SWITCH), .O_FB_SW(O_FB_SW),
  .O_ABUS_OE(O_ABUS_OE), .O_COLUMN_COMPARATOR_BUS(O_COLUMN_COMPARATOR_BUS), .O_B_BRANCH_CAP_SIZE(O_B_BRANCH_CAP_SIZE));
`default_nettype wire
